//--- rll_defs.svh
`ifndef RLL_DEFS_SVH
`define RLL_DEFS_SVH

`define RLL_DEFAULT_ADDR 5'h04
`define RLL_CMD_MASK 8'h7f
`define RLL_CMD_GTL 8'h01
`define RLL_CMD_SDC 8'h04
`define RLL_CMD_GET 8'h08
`define RLL_CMD_LLO 8'h11
`define RLL_CMD_DCL 8'h14
`define RLL_CMD_SPE 8'h18
`define RLL_CMD_SPD 8'h19
`define RLL_CMD_UNL 8'h3f
`define RLL_CMD_UNT 8'h5f
`define RLL_GRP_LISTEN 2'h1
`define RLL_GRP_TALK 2'h2
`define RLL_KEY_LOCAL 8'h30
`define RLL_SYNC_WIDTH 13

`endif

//--- rll_pkg.sv
package rll_pkg;

    typedef enum logic [1:0] {
        RLL_LOCAL,
        RLL_REMOTE,
        RLL_LOCAL_LOCK,
        RLL_REMOTE_LOCK
    } rll_state_type;

    typedef enum logic [1:0] {
        RLL_HS_IDLE,
        RLL_HS_TAKE,
        RLL_HS_DONE
    } rll_hs_type;

    typedef enum logic [1:0] {
        RLL_SER_NONE,
        RLL_SER_REMOTE,
        RLL_SER_LOCAL,
        RLL_SER_LOCKOUT
    } rll_ser_type;

endpackage : rll_pkg

//--- rll_sync.sv
`timescale 1ns/1ns
`include "rll_defs.svh"

module rll_sync (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`RLL_SYNC_WIDTH-1:0] async_in,
    output logic [`RLL_SYNC_WIDTH-1:0] sync_out
);
    import rll_pkg::*;

    logic [`RLL_SYNC_WIDTH-1:0] stage1;
    logic [`RLL_SYNC_WIDTH-1:0] stage2;

    // bus pins are asynchronous to sys_clk
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule : rll_sync

//--- rll_decode.sv
`timescale 1ns/1ns
`include "rll_defs.svh"

module rll_decode (
    input wire logic [7:0] bus_byte,
    input wire logic [4:0] addr,
    output logic is_gtl,
    output logic is_sdc,
    output logic is_get,
    output logic is_llo,
    output logic is_dcl,
    output logic is_spe,
    output logic is_spd,
    output logic is_unl,
    output logic is_unt,
    output logic is_mla,
    output logic is_mta,
    output logic is_ota
);
    import rll_pkg::*;

    logic [7:0] cmd;

    // top data line is blank in every command encoding
    assign cmd = bus_byte & `RLL_CMD_MASK;
    assign is_gtl = (cmd == `RLL_CMD_GTL);
    assign is_sdc = (cmd == `RLL_CMD_SDC);
    assign is_get = (cmd == `RLL_CMD_GET);
    assign is_llo = (cmd == `RLL_CMD_LLO);
    assign is_dcl = (cmd == `RLL_CMD_DCL);
    assign is_spe = (cmd == `RLL_CMD_SPE);
    assign is_spd = (cmd == `RLL_CMD_SPD);
    assign is_unl = (cmd == `RLL_CMD_UNL);
    assign is_unt = (cmd == `RLL_CMD_UNT);
    assign is_mla = (cmd[6:5] == `RLL_GRP_LISTEN) && (cmd[4:0] == addr) && !is_unl;
    assign is_mta = (cmd[6:5] == `RLL_GRP_TALK) && (cmd[4:0] == addr) && !is_unt;
    assign is_ota = (cmd[6:5] == `RLL_GRP_TALK) && (cmd[4:0] != addr);

endmodule : rll_decode

//--- rll_top.sv
`timescale 1ns/1ns
`include "rll_defs.svh"

module rll_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] dio_in,
    input wire logic dav_in,
    input wire logic atn_in,
    input wire logic eoi_in,
    input wire logic ifc_in,
    input wire logic ren_in,
    input wire logic nrfd_in,
    output logic nrfd_out,
    output logic nrfd_oe_n,
    input wire logic ndac_in,
    output logic ndac_out,
    output logic ndac_oe_n,
    input wire logic srq_in,
    output logic srq_out,
    output logic srq_oe_n,
    input wire logic iface_gpib,
    input wire logic addr_load,
    input wire logic [4:0] addr_cfg,
    input wire logic ser_cmd_valid,
    input wire rll_pkg::rll_ser_type ser_cmd,
    input wire logic key_valid,
    input wire logic [7:0] key_code,
    input wire logic srq_request,
    output rll_pkg::rll_state_type op_state,
    output logic remote_indicator,
    output logic lockout_active,
    output logic listen_addressed,
    output logic talk_addressed,
    output logic spoll_active,
    output logic key_out_valid,
    output logic [7:0] key_out_code,
    output logic data_valid,
    output logic [7:0] data_byte,
    output logic data_end,
    output logic dev_clear,
    output logic trigger,
    output logic poll_identify,
    output logic [4:0] my_addr
);
    import rll_pkg::*;

    // synchronised bus lines
    logic [`RLL_SYNC_WIDTH-1:0] pins_s;
    logic [7:0] dio_s;
    logic dav_s;
    logic atn_s;
    logic eoi_s;
    logic ifc_s;
    logic ren_s;

    rll_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in({dio_in, dav_in, atn_in, eoi_in, ifc_in, ren_in}),
        .sync_out(pins_s)
    );

    assign {dio_s, dav_s, atn_s, eoi_s, ifc_s, ren_s} = pins_s;

    // address register
    logic [4:0] next_my_addr;

    always_comb begin
        next_my_addr = my_addr;
        if (addr_load) begin
            next_my_addr = addr_cfg;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            my_addr <= `RLL_DEFAULT_ADDR;
        end else begin
            my_addr <= next_my_addr;
        end
    end

    // acceptor handshake and captured byte
    rll_hs_type hs;
    rll_hs_type next_hs;
    logic [7:0] byte_q;
    logic [7:0] next_byte_q;
    logic atn_q;
    logic next_atn_q;
    logic eoi_q;
    logic next_eoi_q;
    logic next_nrfd_oe_n;
    logic next_ndac_oe_n;
    logic participate;

    // attention bytes are taken by every device
    assign participate = atn_s || listen_addressed;

    always_comb begin
        next_hs = hs;
        next_byte_q = byte_q;
        next_atn_q = atn_q;
        next_eoi_q = eoi_q;
        case (hs)
            RLL_HS_IDLE: begin
                if (participate && dav_s && !ifc_s) begin
                    next_hs = RLL_HS_TAKE;
                    next_byte_q = dio_s;
                    next_atn_q = atn_s;
                    next_eoi_q = eoi_s;
                end
            end
            RLL_HS_TAKE: begin
                next_hs = RLL_HS_DONE;
            end
            RLL_HS_DONE: begin
                if (!dav_s) begin
                    next_hs = RLL_HS_IDLE;
                end
            end
            default: begin
                next_hs = RLL_HS_IDLE;
            end
        endcase
        // not ready until the talker drops data valid again
        next_nrfd_oe_n = (next_hs == RLL_HS_IDLE);
        // hold data-not-accepted until the byte is taken
        next_ndac_oe_n = !(participate && next_hs == RLL_HS_IDLE);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hs <= RLL_HS_IDLE;
            byte_q <= 8'h00;
            atn_q <= 1'b0;
            eoi_q <= 1'b0;
            nrfd_oe_n <= 1'b1;
            ndac_oe_n <= 1'b1;
        end else begin
            hs <= next_hs;
            byte_q <= next_byte_q;
            atn_q <= next_atn_q;
            eoi_q <= next_eoi_q;
            nrfd_oe_n <= next_nrfd_oe_n;
            ndac_oe_n <= next_ndac_oe_n;
        end
    end

    // command decode of the captured byte
    logic is_gtl;
    logic is_sdc;
    logic is_get;
    logic is_llo;
    logic is_dcl;
    logic is_spe;
    logic is_spd;
    logic is_unl;
    logic is_unt;
    logic is_mla;
    logic is_mta;
    logic is_ota;

    rll_decode u_decode (
        .bus_byte(byte_q),
        .addr(my_addr),
        .is_gtl(is_gtl),
        .is_sdc(is_sdc),
        .is_get(is_get),
        .is_llo(is_llo),
        .is_dcl(is_dcl),
        .is_spe(is_spe),
        .is_spd(is_spd),
        .is_unl(is_unl),
        .is_unt(is_unt),
        .is_mla(is_mla),
        .is_mta(is_mta),
        .is_ota(is_ota)
    );

    logic take;
    logic cmd_take;
    logic dat_take;
    logic gtl_ev;
    logic llo_ev;
    logic mla_ev;

    assign take = (hs == RLL_HS_TAKE);
    // attention selects command versus data meaning
    assign cmd_take = take && atn_q;
    assign dat_take = take && !atn_q;
    // go-to-local is addressed: only a listener obeys it
    assign gtl_ev = cmd_take && is_gtl && listen_addressed;
    assign llo_ev = cmd_take && is_llo;
    assign mla_ev = cmd_take && is_mla;

    // bus addressing and pulses
    logic next_listen;
    logic next_talk;
    logic next_spoll;
    logic next_data_valid;
    logic [7:0] next_data_byte;
    logic next_data_end;
    logic next_dev_clear;
    logic next_trigger;
    logic next_poll_identify;
    logic next_srq_oe_n;

    always_comb begin
        next_listen = listen_addressed;
        next_talk = talk_addressed;
        next_spoll = spoll_active;
        if (ifc_s) begin
            // interface clear ends talking, listening and serial poll
            next_listen = 1'b0;
            next_talk = 1'b0;
            next_spoll = 1'b0;
        end else if (cmd_take) begin
            // unlisten, untalk and poll modes only from the bus
            if (is_mla) begin
                next_listen = 1'b1;
            end else if (is_unl) begin
                next_listen = 1'b0;
            end
            if (is_mta) begin
                next_talk = 1'b1;
            end else if (is_unt || is_ota) begin
                next_talk = 1'b0;
            end
            if (is_spe) begin
                next_spoll = 1'b1;
            end else if (is_spd) begin
                next_spoll = 1'b0;
            end
        end
        // data bytes pass through, never parsed for state commands
        next_data_valid = dat_take;
        next_data_byte = dat_take ? byte_q : data_byte;
        // end-or-identify marks the last data byte
        next_data_end = dat_take && eoi_q;
        // clear and trigger have no serial path
        next_dev_clear = cmd_take && (is_dcl || (is_sdc && listen_addressed));
        next_trigger = cmd_take && is_get && listen_addressed;
        // end-or-identify with attention is a poll
        next_poll_identify = atn_s && eoi_s;
        next_srq_oe_n = !srq_request;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            listen_addressed <= 1'b0;
            talk_addressed <= 1'b0;
            spoll_active <= 1'b0;
            data_valid <= 1'b0;
            data_byte <= 8'h00;
            data_end <= 1'b0;
            dev_clear <= 1'b0;
            trigger <= 1'b0;
            poll_identify <= 1'b0;
            srq_oe_n <= 1'b1;
        end else begin
            listen_addressed <= next_listen;
            talk_addressed <= next_talk;
            spoll_active <= next_spoll;
            data_valid <= next_data_valid;
            data_byte <= next_data_byte;
            data_end <= next_data_end;
            dev_clear <= next_dev_clear;
            trigger <= next_trigger;
            poll_identify <= next_poll_identify;
            srq_oe_n <= next_srq_oe_n;
        end
    end

    // open-drain lines only ever pull low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nrfd_out <= 1'b0;
            ndac_out <= 1'b0;
            srq_out <= 1'b0;
        end else begin
            nrfd_out <= 1'b0;
            ndac_out <= 1'b0;
            srq_out <= 1'b0;
        end
    end

    // remote/local state
    rll_state_type next_state;
    logic next_remote_indicator;
    logic next_lockout;
    logic next_key_valid;
    logic [7:0] next_key_code;
    logic ser_remote;
    logic ser_local;
    logic ser_lockout;
    logic local_key;
    logic lock_req;
    logic remote_req;

    // serial framing lives upstream; only decoded commands arrive here
    assign ser_remote = ser_cmd_valid && (ser_cmd == RLL_SER_REMOTE);
    assign ser_local = ser_cmd_valid && (ser_cmd == RLL_SER_LOCAL);
    assign ser_lockout = ser_cmd_valid && (ser_cmd == RLL_SER_LOCKOUT);
    assign local_key = key_valid && (key_code == `RLL_KEY_LOCAL);
    // lockout from bus message or serial command
    assign lock_req = llo_ev || ser_lockout;
    // remote from serial command or listen address with remote-enable
    assign remote_req = ser_remote || (mla_ev && ren_s);

    always_comb begin
        next_state = op_state;
        // one of four states; lockout applied before remote entry
        case (op_state)
            RLL_LOCAL: begin
                if (lock_req) begin
                    next_state = remote_req ? RLL_REMOTE_LOCK : RLL_LOCAL_LOCK;
                end else if (remote_req) begin
                    next_state = RLL_REMOTE;
                end
            end
            RLL_REMOTE: begin
                // local key, serial local or go-to-local release
                if (lock_req) begin
                    next_state = RLL_REMOTE_LOCK;
                end else if (local_key || ser_local || gtl_ev) begin
                    next_state = RLL_LOCAL;
                end
            end
            RLL_LOCAL_LOCK: begin
                if (remote_req) begin
                    next_state = RLL_REMOTE_LOCK;
                end else if (ser_local) begin
                    next_state = RLL_LOCAL;
                end
            end
            RLL_REMOTE_LOCK: begin
                if (gtl_ev || ser_local) begin
                    next_state = RLL_LOCAL_LOCK;
                end
            end
            default: begin
                next_state = RLL_LOCAL;
            end
        endcase
        // remote-enable false overrides everything on the bus
        if (iface_gpib && !ren_s) begin
            next_state = RLL_LOCAL;
        end
        // remote indicator in both remote states
        next_remote_indicator = (next_state == RLL_REMOTE) || (next_state == RLL_REMOTE_LOCK);
        next_lockout = (next_state == RLL_LOCAL_LOCK) || (next_state == RLL_REMOTE_LOCK);
        next_key_valid = key_valid && ((op_state == RLL_LOCAL) || (op_state == RLL_LOCAL_LOCK));
        next_key_code = next_key_valid ? key_code : key_out_code;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            op_state <= RLL_LOCAL;
            remote_indicator <= 1'b0;
            lockout_active <= 1'b0;
            key_out_valid <= 1'b0;
            key_out_code <= 8'h00;
        end else begin
            op_state <= next_state;
            remote_indicator <= next_remote_indicator;
            lockout_active <= next_lockout;
            key_out_valid <= next_key_valid;
            key_out_code <= next_key_code;
        end
    end

endmodule : rll_top

//--- rll_sva.sv
`timescale 1ns/1ns

module rll_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ren_in,
    input wire logic ifc_in,
    input wire logic dav_in,
    input wire logic iface_gpib,
    input wire logic ser_cmd_valid,
    input wire rll_pkg::rll_ser_type ser_cmd,
    input wire logic key_valid,
    input wire logic [7:0] key_code,
    input wire logic srq_request,
    input wire logic nrfd_oe_n,
    input wire logic srq_oe_n,
    input wire rll_pkg::rll_state_type op_state,
    input wire logic remote_indicator,
    input wire logic lockout_active,
    input wire logic listen_addressed,
    input wire logic talk_addressed,
    input wire logic key_out_valid,
    input wire logic [7:0] key_out_code
);
    import rll_pkg::*;

    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_remote_shown: assert property (
        remote_indicator == (op_state inside {RLL_REMOTE, RLL_REMOTE_LOCK}))
        else $error("remote indicator disagrees with state");
    a_lockout_shown: assert property (
        lockout_active == (op_state inside {RLL_LOCAL_LOCK, RLL_REMOTE_LOCK}))
        else $error("lockout flag disagrees with state");
    a_serial_remote: assert property (
        ser_cmd_valid && ser_cmd == RLL_SER_REMOTE && !iface_gpib && !lockout_active
            && !key_valid |=> op_state == RLL_REMOTE)
        else $error("serial remote did not enter remote");
    a_lock_any: assert property (
        ser_cmd_valid && ser_cmd == RLL_SER_LOCKOUT && !iface_gpib
            |=> lockout_active && remote_indicator == $past(remote_indicator))
        else $error("lockout request mishandled");
    a_local_key: assert property (
        key_valid && key_code == 8'h30 && op_state == RLL_REMOTE && !ser_cmd_valid
            && !iface_gpib |=> op_state == RLL_LOCAL)
        else $error("local key did not return to local");
    a_keys_blocked: assert property (
        key_valid && remote_indicator |=> !key_out_valid)
        else $error("key passed while remote");
    a_key_passed: assert property (
        key_valid && op_state == RLL_LOCAL |=> key_out_valid && key_out_code == $past(key_code))
        else $error("key not passed in local");
    a_ren_drops: assert property (
        (iface_gpib && !ren_in) [*4] |-> op_state == RLL_LOCAL)
        else $error("remote enable false did not force local");
    // ready restored after data valid drops
    a_ready_back: assert property (
        !dav_in [*4] |-> nrfd_oe_n)
        else $error("not ready held after data valid fell");
    a_ifc_clears: assert property (
        ifc_in [*4] |-> !listen_addressed && !talk_addressed)
        else $error("interface clear left device addressed");
    a_srq_follow: assert property (
        srq_request == $past(srq_request) |-> srq_oe_n == !srq_request)
        else $error("service request line wrong");
endmodule : rll_chk

bind rll_top rll_chk i_rll_chk (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ren_in(ren_in),
    .ifc_in(ifc_in),
    .dav_in(dav_in),
    .iface_gpib(iface_gpib),
    .ser_cmd_valid(ser_cmd_valid),
    .ser_cmd(ser_cmd),
    .key_valid(key_valid),
    .key_code(key_code),
    .srq_request(srq_request),
    .nrfd_oe_n(nrfd_oe_n),
    .srq_oe_n(srq_oe_n),
    .op_state(op_state),
    .remote_indicator(remote_indicator),
    .lockout_active(lockout_active),
    .listen_addressed(listen_addressed),
    .talk_addressed(talk_addressed),
    .key_out_valid(key_out_valid),
    .key_out_code(key_out_code)
);

//--- rll_ctrl_model.sv
`timescale 1ns/1ns

module rll_ctrl_model (
    input wire logic sys_clk,
    input wire logic nrfd_oe_n,
    input wire logic ndac_oe_n,
    output logic [7:0] dio_in,
    output logic dav_in,
    output logic atn_in,
    output logic eoi_in
);
    int hs_errors = 0;

    initial begin
        dio_in = 8'h00;
        dav_in = 1'b0;
        atn_in = 1'b0;
        eoi_in = 1'b0;
    end

    // one byte per handshake, true is 1
    task automatic send_byte(input logic atn, input logic [7:0] b, input logic eoi);
        int n;
        n = 0;
        @(posedge sys_clk);
        atn_in <= atn;
        eoi_in <= eoi;
        dio_in <= b;
        dav_in <= 1'b1;
        // dav must be seen through the synchroniser before ndac can mean anything
        repeat (5) @(posedge sys_clk);
        while (ndac_oe_n !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        dav_in <= 1'b0;
        eoi_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
        // released lines no longer carry the byte
        dio_in <= ~b;
        while (nrfd_oe_n !== 1'b1 && n < 80) begin
            @(posedge sys_clk);
            n++;
        end
        atn_in <= 1'b0;
        if (n >= 40) begin
            hs_errors++;
        end
    endtask : send_byte
endmodule : rll_ctrl_model

//--- tb.sv
`timescale 1ns/1ns

module tb;
    import rll_pkg::*;

    typedef struct {logic is_key; logic [7:0] val; rll_state_type exp; logic pass;} rll_row_type;
    typedef struct {logic atn; logic [7:0] b; logic eoi; rll_state_type exp;} rll_brow_type;

    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] dio_in;
    logic dav_in, atn_in, eoi_in, nrfd_out, nrfd_oe_n, ndac_out, ndac_oe_n, srq_out, srq_oe_n;
    logic ifc_in = 1'b0;
    logic ren_in = 1'b0;
    logic iface_gpib = 1'b0;
    logic addr_load = 1'b0;
    logic [4:0] addr_cfg = 5'h04;
    logic ser_cmd_valid = 1'b0;
    rll_ser_type ser_cmd = RLL_SER_NONE;
    logic key_valid = 1'b0;
    logic [7:0] key_code = 8'h00;
    logic srq_request = 1'b0;
    rll_state_type op_state;
    logic remote_indicator, lockout_active, listen_addressed, talk_addressed, spoll_active;
    logic key_out_valid, data_valid, data_end, dev_clear, trigger, poll_identify;
    logic [7:0] key_out_code, data_byte;
    logic [4:0] my_addr;
    logic last_end = 1'b0;
    int n_data = 0;
    int n_clear = 0;
    int n_trig = 0;
    int n_poll = 0;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    rll_row_type rows [16];
    rll_brow_type brows [6];

    // open-drain wires: pulled true while the device's enable is low
    wire logic nrfd_in = ~nrfd_oe_n;
    wire logic ndac_in = ~ndac_oe_n;
    wire logic srq_in = ~srq_oe_n;

    always #2 sys_clk = ~sys_clk;

    rll_ctrl_model i_rll_ctrl_model (.sys_clk(sys_clk), .nrfd_oe_n(nrfd_oe_n),
        .ndac_oe_n(ndac_oe_n), .dio_in(dio_in), .dav_in(dav_in), .atn_in(atn_in),
        .eoi_in(eoi_in));

    rll_top i_rll_top (.sys_clk(sys_clk), .nrst(nrst), .dio_in(dio_in), .dav_in(dav_in),
        .atn_in(atn_in), .eoi_in(eoi_in), .ifc_in(ifc_in), .ren_in(ren_in),
        .nrfd_in(nrfd_in), .nrfd_out(nrfd_out), .nrfd_oe_n(nrfd_oe_n), .ndac_in(ndac_in),
        .ndac_out(ndac_out), .ndac_oe_n(ndac_oe_n), .srq_in(srq_in), .srq_out(srq_out),
        .srq_oe_n(srq_oe_n), .iface_gpib(iface_gpib), .addr_load(addr_load),
        .addr_cfg(addr_cfg), .ser_cmd_valid(ser_cmd_valid), .ser_cmd(ser_cmd),
        .key_valid(key_valid), .key_code(key_code), .srq_request(srq_request),
        .op_state(op_state), .remote_indicator(remote_indicator),
        .lockout_active(lockout_active), .listen_addressed(listen_addressed),
        .talk_addressed(talk_addressed), .spoll_active(spoll_active),
        .key_out_valid(key_out_valid), .key_out_code(key_out_code), .data_valid(data_valid),
        .data_byte(data_byte), .data_end(data_end), .dev_clear(dev_clear), .trigger(trigger),
        .poll_identify(poll_identify), .my_addr(my_addr));

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (data_valid === 1'b1) begin
            last_end <= data_end;
            n_data <= n_data + 1;
        end
        if (dev_clear === 1'b1) begin
            n_clear <= n_clear + 1;
        end
        if (trigger === 1'b1) begin
            n_trig <= n_trig + 1;
        end
        if (poll_identify === 1'b1) begin
            n_poll <= n_poll + 1;
        end
        if (cyc == 6000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic bus_send(input logic atn, input logic [7:0] b, input logic eoi);
        i_rll_ctrl_model.send_byte(atn, b, eoi);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : bus_send

    initial begin
        rows = '{'{0, 8'h01, RLL_REMOTE, 0}, '{1, 8'h41, RLL_REMOTE, 0},
            '{1, 8'h30, RLL_LOCAL, 0}, '{1, 8'h41, RLL_LOCAL, 1},
            '{0, 8'h03, RLL_LOCAL_LOCK, 0}, '{1, 8'h41, RLL_LOCAL_LOCK, 1},
            '{0, 8'h01, RLL_REMOTE_LOCK, 0}, '{1, 8'h30, RLL_REMOTE_LOCK, 0},
            '{0, 8'h02, RLL_LOCAL_LOCK, 0}, '{0, 8'h02, RLL_LOCAL, 0},
            '{0, 8'h01, RLL_REMOTE, 0}, '{0, 8'h02, RLL_LOCAL, 0},
            '{0, 8'h01, RLL_REMOTE, 0}, '{0, 8'h03, RLL_REMOTE_LOCK, 0},
            '{0, 8'h02, RLL_LOCAL_LOCK, 0}, '{0, 8'h02, RLL_LOCAL, 0}};
        brows = '{'{1, 8'h24, 0, RLL_REMOTE}, '{1, 8'h11, 0, RLL_REMOTE_LOCK},
            '{1, 8'h01, 0, RLL_LOCAL_LOCK}, '{1, 8'h24, 0, RLL_REMOTE_LOCK},
            '{0, 8'h01, 1, RLL_REMOTE_LOCK}, '{1, 8'h14, 0, RLL_REMOTE_LOCK}};
        repeat (5) @(posedge sys_clk);
        #1;
        check({6'h00, op_state}, {6'h00, RLL_LOCAL});
        check({3'h0, my_addr}, 8'h04);
        check({5'h00, nrfd_oe_n, ndac_oe_n, srq_oe_n}, 8'h07);
        @(posedge sys_clk);
        nrst <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            key_valid <= rows[i].is_key;
            ser_cmd_valid <= !rows[i].is_key;
            key_code <= rows[i].val;
            ser_cmd <= rll_ser_type'(rows[i].val[1:0]);
            @(posedge sys_clk);
            key_valid <= 1'b0;
            ser_cmd_valid <= 1'b0;
            #1;
            check({6'h00, op_state}, {6'h00, rows[i].exp});
            check({7'h00, key_out_valid}, {7'h00, rows[i].pass});
            if (rows[i].pass) begin
                check(key_out_code, rows[i].val);
            end
        end
        $display("test serial and keys done");
        @(posedge sys_clk);
        iface_gpib <= 1'b1;
        ren_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            bus_send(brows[i].atn, brows[i].b, brows[i].eoi);
            check({6'h00, op_state}, {6'h00, brows[i].exp});
        end
        check({7'h00, listen_addressed}, 8'h01);
        check(data_byte, 8'h01);
        check({7'h00, last_end}, 8'h01);
        check(8'(n_data), 8'h01);
        check(8'(n_clear), 8'h01);
        $display("test bus messages done");
        @(posedge sys_clk);
        ren_in <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check({6'h00, op_state}, {6'h00, RLL_LOCAL});
        @(posedge sys_clk);
        ren_in <= 1'b1;
        bus_send(1'b1, 8'h44, 1'b0);
        check({7'h00, talk_addressed}, 8'h01);
        @(posedge sys_clk);
        ifc_in <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check({6'h00, talk_addressed, listen_addressed}, 8'h00);
        @(posedge sys_clk);
        ifc_in <= 1'b0;
        addr_cfg <= 5'h0a;
        addr_load <= 1'b1;
        @(posedge sys_clk);
        addr_load <= 1'b0;
        #1;
        check({3'h0, my_addr}, 8'h0a);
        bus_send(1'b1, 8'h24, 1'b0);
        check({7'h00, listen_addressed}, 8'h00);
        bus_send(1'b1, 8'h2a, 1'b0);
        check({7'h00, listen_addressed}, 8'h01);
        bus_send(1'b1, 8'h08, 1'b0);
        check(8'(n_trig), 8'h01);
        bus_send(1'b1, 8'h18, 1'b1);
        check({7'h00, spoll_active}, 8'h01);
        check({7'h00, (n_poll > 0)}, 8'h01);
        bus_send(1'b1, 8'h19, 1'b0);
        check({7'h00, spoll_active}, 8'h00);
        $display("test remote enable and clear done");
        @(posedge sys_clk);
        srq_request <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check({7'h00, srq_oe_n}, 8'h00);
        @(posedge sys_clk);
        srq_request <= 1'b0;
        check(8'(i_rll_ctrl_model.hs_errors), 8'h00);
        $display("test service request done");
        tally_and_finish();
    end
endmodule : tb
